// [core/add_and_bit_defines.svh]
`ifndef ADD_AND_BIT_DEFINES_SVH
`define ADD_AND_BIT_DEFINES_SVH

// Instruction word and datapath widths
`define INSTR_W        14
`define DATA_W         8
`define ADDR_W         7
`define SYNC_STAGES    3

// Instruction field positions
`define MAJ_HI         13
`define MAJ_LO         12
`define SUB_HI         11
`define SUB_LO         8
`define LIT_ADD_LO     9
`define DEST_BIT       7
`define ADDR_HI        6
`define ADDR_LO        0
`define MINOR_HI       11
`define MINOR_LO       10
`define BITSEL_HI      9
`define BITSEL_LO      7
`define LIT_HI         7
`define LIT_LO         0
`define NIBBLE_MSB     3

// Major opcode codes
`define MAJ_BYTE       2'h0
`define MAJ_BIT        2'h1
`define MAJ_LIT        2'h3

// Byte-oriented sub codes
`define SUB_ADD_REG    4'h7
`define SUB_AND_REG    4'h5

// Literal sub codes (add ignores the lowest sub bit)
`define SUB_ADD_IMM    3'h7
`define SUB_AND_IMM    4'h9

// Bit-oriented minor codes
`define MINOR_CLR      2'h0
`define MINOR_SET      2'h1
`define MINOR_SKIP_LO  2'h2
`define MINOR_SKIP_HI  2'h3

// Result target select
`define DEST_ACC       1'b0

// Reset values
`define ACC_RST        8'h00
`define ADDR_RST       7'h00
`define ONE_HOT_BIT0   8'h01

`endif

// [core/add_and_bit_op_execute.sv]
`include "add_and_bit_defines.svh"
`default_nettype none

// Operation
// - add immediate into accumulator, update carry flags
// - add accumulator and register, update carry flags
// - target zero accumulator, one file register
// - and immediate into accumulator, zero only
// - and register, routed by target, zero only
// - bit clear, other bits and flags kept
// - bit set, other bits and flags kept
// - skip next if tested bit low
// - skip next if tested bit high
// - bit ops decode major 01, minor codes
// - port read-modify-write uses pin levels
module add_and_bit_op_execute (
   input  wire logic                 sys_clk,       // Core clock, 250 MHz
   input  wire logic                 rst_n,         // Synchronous reset, active low
   input  wire logic [`INSTR_W-1:0]  instrWord,     // Instruction to execute
   input  wire logic                 instrValid,    // Instruction offered
   input  wire logic [`DATA_W-1:0]   fileRdData,    // Addressed file register value
   input  wire logic                 operandIsPort, // Addressed register is an I/O port
   input  wire logic [`DATA_W-1:0]   portPins,      // Asynchronous port pin levels
   output logic                      instrReady,    // Instruction accepted when valid
   output logic [`DATA_W-1:0]        accum,         // Accumulator
   output logic                      carryFlag,     // Unsigned overflow flag
   output logic                      nibbleFlag,    // Nibble overflow flag
   output logic                      zeroFlag,      // All bits low flag
   output logic                      fileWrEn,      // File register write pulse
   output logic [`ADDR_W-1:0]        fileWrAddr,    // File register write address
   output logic [`DATA_W-1:0]        fileWrData,    // File register write data
   output logic                      discardPulse   // Next instruction replaced by NOP
);

   add_and_bit_pkg::exec_state_t stateQ, stateD;      // Execute state
   logic                  readyQ, readyD;             // Accept flag
   logic [`DATA_W-1:0]    accQ, accD;                 // Accumulator
   logic                  carryQ, carryD;             // Carry flag
   logic                  nibQ, nibD;                 // Nibble carry flag
   logic                  zeroQ, zeroD;               // Zero flag
   logic                  wrEnQ, wrEnD;               // Write strobe
   logic [`ADDR_W-1:0]    wrAddrQ, wrAddrD;           // Write address
   logic [`DATA_W-1:0]    wrDataQ, wrDataD;           // Write data
   logic                  discardQ, discardD;         // Discard pulse
   logic [`DATA_W-1:0]    pinS1Q, pinS2Q, pinS3Q;     // Pin synchroniser chain
   logic [`DATA_W-1:0]    pinStableQ, pinStableD;     // Agreed pin levels
   logic [`DATA_W-1:0]    operand;                    // Register operand
   logic [`DATA_W-1:0]    addB;                       // Second addend
   logic [`DATA_W-1:0]    sum;                        // Adder sum
   logic                  sumCarry;                   // Adder carry out
   logic                  sumNib;                     // Adder nibble carry
   logic                  take;                       // Instruction taken
   logic [1:0]            major;                      // Major opcode
   logic [3:0]            sub;                        // Byte or literal sub code
   logic [1:0]            minor;                      // Bit op minor code
   logic [2:0]            bitSel;                     // Selected bit
   logic                  destSel;                    // Result target
   logic [`ADDR_W-1:0]    regAddr;                    // File register address
   logic [`DATA_W-1:0]    literal;                    // Immediate value
   logic [`DATA_W-1:0]    bitMask;                    // One-hot bit mask
   logic                  testBit;                    // Tested bit value
   logic                  isAddImm, isAndImm;         // Literal ops
   logic                  isAddReg, isAndReg;         // Byte ops
   logic                  isBitOp;                    // Bit-oriented group

   // Field extraction
   assign major   = instrWord[`MAJ_HI:`MAJ_LO];
   assign sub     = instrWord[`SUB_HI:`SUB_LO];
   assign minor   = instrWord[`MINOR_HI:`MINOR_LO];
   assign bitSel  = instrWord[`BITSEL_HI:`BITSEL_LO];
   assign destSel = instrWord[`DEST_BIT];
   assign regAddr = instrWord[`ADDR_HI:`ADDR_LO];
   assign literal = instrWord[`LIT_HI:`LIT_LO];
   assign take    = instrValid && readyQ;

   assign isBitOp  = (major == `MAJ_BIT);
   assign isAddImm = (major == `MAJ_LIT) && (instrWord[`SUB_HI:`LIT_ADD_LO] == `SUB_ADD_IMM);
   assign isAndImm = (major == `MAJ_LIT) && (sub == `SUB_AND_IMM);
   assign isAddReg = (major == `MAJ_BYTE) && (sub == `SUB_ADD_REG);
   assign isAndReg = (major == `MAJ_BYTE) && (sub == `SUB_AND_REG);

   assign operand = operandIsPort ? pinStableQ : fileRdData;
   assign addB    = (major == `MAJ_LIT) ? literal : operand;
   assign bitMask = `ONE_HOT_BIT0 << bitSel;
   assign testBit = operand[bitSel];

   // Shared adder for both add forms
   nibble_adder #(
      .WIDTH (`DATA_W),
      .NIB   (`NIBBLE_MSB + 1)
   ) u_adder (
      .opA      (accQ),
      .opB      (addB),
      .sum      (sum),
      .carryOut (sumCarry),
      .nibCarry (sumNib)
   );

   // Pin synchroniser, one per bit
   genvar gi;
   generate
      for (gi = 0; gi < `DATA_W; gi++)
      begin : g_pin
         // Accept a level once stages two and three agree
         always_comb
         begin
            pinStableD[gi] = (pinS2Q[gi] == pinS3Q[gi]) ? pinS3Q[gi] : pinStableQ[gi];
         end

         // Register chain
         always_ff @(posedge sys_clk)
         begin
            pinS1Q[gi]     <= portPins[gi];
            pinS2Q[gi]     <= pinS1Q[gi];
            pinS3Q[gi]     <= pinS2Q[gi];
            pinStableQ[gi] <= rst_n ? pinStableD[gi] : 1'b0;
         end
      end
   endgenerate

   // Next-state and datapath
   always_comb
   begin
      stateD   = stateQ;
      readyD   = 1'b1;
      accD     = accQ;
      carryD   = carryQ;
      nibD     = nibQ;
      zeroD    = zeroQ;
      wrEnD    = 1'b0;
      wrAddrD  = wrAddrQ;
      wrDataD  = wrDataQ;
      discardD = 1'b0;
      if (take)
      begin
         if (stateQ == add_and_bit_pkg::ST_SKIP)
         begin
            discardD = 1'b1;
            stateD   = add_and_bit_pkg::ST_RUN;
         end
         else if (isAddImm)
         begin
            accD   = sum;
            carryD = sumCarry;
            nibD   = sumNib;
            zeroD  = (sum == `ACC_RST);
         end
         else if (isAndImm)
         begin
            accD  = accQ & literal;
            zeroD = ((accQ & literal) == `ACC_RST);
         end
         else if (isAddReg || isAndReg)
         begin
            wrDataD = isAddReg ? sum : (accQ & operand);
            zeroD   = (wrDataD == `ACC_RST);
            if (isAddReg)
            begin
               carryD = sumCarry;
               nibD   = sumNib;
            end
            if (destSel == `DEST_ACC)
            begin
               accD = wrDataD;
            end
            else
            begin
               wrEnD   = 1'b1;
               wrAddrD = regAddr;
            end
         end
         else if (isBitOp)
         begin
            unique case (minor)
               `MINOR_CLR:
               begin
                  wrEnD   = 1'b1;
                  wrAddrD = regAddr;
                  wrDataD = operand & ~bitMask;
               end
               `MINOR_SET:
               begin
                  wrEnD   = 1'b1;
                  wrAddrD = regAddr;
                  wrDataD = operand | bitMask;
               end
               `MINOR_SKIP_LO:
               begin
                  if (!testBit)
                  begin
                     stateD = add_and_bit_pkg::ST_SKIP;
                  end
               end
               `MINOR_SKIP_HI:
               begin
                  if (testBit)
                  begin
                     stateD = add_and_bit_pkg::ST_SKIP;
                  end
               end
            endcase
         end
      end
   end

   // State registers
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         stateQ   <= add_and_bit_pkg::ST_RUN;
         readyQ   <= 1'b0;
         accQ     <= `ACC_RST;
         carryQ   <= 1'b0;
         nibQ     <= 1'b0;
         zeroQ    <= 1'b0;
         wrEnQ    <= 1'b0;
         wrAddrQ  <= `ADDR_RST;
         wrDataQ  <= `ACC_RST;
         discardQ <= 1'b0;
      end
      else
      begin
         stateQ   <= stateD;
         readyQ   <= readyD;
         accQ     <= accD;
         carryQ   <= carryD;
         nibQ     <= nibD;
         zeroQ    <= zeroD;
         wrEnQ    <= wrEnD;
         wrAddrQ  <= wrAddrD;
         wrDataQ  <= wrDataD;
         discardQ <= discardD;
      end
   end

   // Outputs straight from flops
   assign instrReady   = readyQ;
   assign accum        = accQ;
   assign carryFlag    = carryQ;
   assign nibbleFlag   = nibQ;
   assign zeroFlag     = zeroQ;
   assign fileWrEn     = wrEnQ;
   assign fileWrAddr   = wrAddrQ;
   assign fileWrData   = wrDataQ;
   assign discardPulse = discardQ;

   logic runTake;  // Taken outside a skip
   assign runTake = take && (stateQ == add_and_bit_pkg::ST_RUN);

   // Immediate add result and carry
   property p_add_imm;
      @(posedge sys_clk) disable iff (!rst_n)
      runTake && isAddImm |=> accQ == 8'($past(accQ) + $past(literal))
         && carryQ == (9'($past(accQ)) + 9'($past(literal)) > 9'h0ff);
   endproperty
   a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");

   // Register add to file register
   property p_add_reg_file;
      @(posedge sys_clk) disable iff (!rst_n)
      runTake && isAddReg && destSel |=> wrEnQ && wrAddrQ == $past(regAddr)
         && wrDataQ == 8'($past(accQ) + $past(operand)) && $stable(accQ);
   endproperty
   a_add_reg_file: assert property (p_add_reg_file) else $error("add to file wrong");

   // Target zero keeps file untouched
   property p_dest_acc;
      @(posedge sys_clk) disable iff (!rst_n)
      runTake && (isAddReg || isAndReg) && !destSel |=> !wrEnQ && accQ == wrDataQ;
   endproperty
   a_dest_acc: assert property (p_dest_acc) else $error("target select wrong");

   // Immediate and leaves carries alone
   property p_and_imm;
      @(posedge sys_clk) disable iff (!rst_n)
      runTake && isAndImm |=> $stable(carryQ) && $stable(nibQ)
         && accQ == ($past(accQ) & $past(literal)) && zeroQ == (accQ == 8'h00);
   endproperty
   a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");

   // Register and result
   property p_and_reg;
      @(posedge sys_clk) disable iff (!rst_n)
      runTake && isAndReg |=> wrDataQ == ($past(accQ) & $past(operand)) && $stable(carryQ);
   endproperty
   a_and_reg: assert property (p_and_reg) else $error("and register wrong");

   // Bit clear and set touch one bit only
   property p_bit_write;
      @(posedge sys_clk) disable iff (!rst_n)
      runTake && isBitOp && !minor[1] |=> wrEnQ && $stable(zeroQ) && $stable(carryQ)
         && wrDataQ[$past(bitSel)] == $past(minor[0])
         && (wrDataQ & ~$past(bitMask)) == ($past(operand) & ~$past(bitMask));
   endproperty
   a_bit_write: assert property (p_bit_write) else $error("bit write wrong");

   // Skip on low bit takes the NOP cycle
   property p_skip_lo;
      @(posedge sys_clk) disable iff (!rst_n)
      runTake && isBitOp && minor == `MINOR_SKIP_LO && !testBit
         |=> stateQ == add_and_bit_pkg::ST_SKIP && !wrEnQ && $stable(zeroQ);
   endproperty
   a_skip_lo: assert property (p_skip_lo) else $error("skip low missed");

   // Both skip tests: skip when the tested bit equals the minor low bit, and no skip otherwise
   property p_skip_hi;
      @(posedge sys_clk) disable iff (!rst_n)
      runTake && isBitOp && minor[1] |=> (stateQ == add_and_bit_pkg::ST_SKIP)
         == ($past(testBit) == $past(minor[0]));
   endproperty
   a_skip_hi: assert property (p_skip_hi) else $error("skip high wrong");

   // Discarded instruction changes nothing
   property p_discard;
      @(posedge sys_clk) disable iff (!rst_n)
      take && stateQ == add_and_bit_pkg::ST_SKIP |=> discardQ && !wrEnQ
         && $stable(accQ) && stateQ == add_and_bit_pkg::ST_RUN;
   endproperty
   a_discard: assert property (p_discard) else $error("discard wrong");

   // Zero flag follows add result
   property p_zero;
      @(posedge sys_clk) disable iff (!rst_n)
      runTake && isAddReg |=> zeroQ == (wrDataQ == 8'h00) && nibQ == $past(sumNib);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule

`default_nettype wire

// [core/add_and_bit_pkg.sv]
`default_nettype none

package add_and_bit_pkg;

   // Sequencing state of the execute stage
   typedef enum logic [0:0]
   {
      ST_RUN,
      ST_SKIP
   } exec_state_t;

endpackage

`default_nettype wire

// [core/nibble_adder.sv]
`default_nettype none

// Adder giving sum, carry out of the top bit and carry out of the low nibble
module nibble_adder #(
   parameter int WIDTH = 8,   // Operand width
   parameter int NIB   = 4    // Bits below the nibble carry
)(
   input  wire logic [WIDTH-1:0] opA,       // First addend
   input  wire logic [WIDTH-1:0] opB,       // Second addend
   output logic      [WIDTH-1:0] sum,       // Truncated sum
   output logic                  carryOut,  // Carry out of top bit
   output logic                  nibCarry   // Carry out of low nibble
);

   logic [WIDTH:0] full;  // Full-width sum
   logic [NIB:0]   low;   // Low nibble sum

   // Whole-word and low-nibble additions
   always_comb
   begin
      full     = {1'b0, opA} + {1'b0, opB};
      low      = {1'b0, opA[NIB-1:0]} + {1'b0, opB[NIB-1:0]};
      sum      = full[WIDTH-1:0];
      carryOut = full[WIDTH];
      nibCarry = low[NIB];
   end

endmodule

`default_nettype wire

// [dv/file_space_model.sv]
`default_nettype none

// File register space seen by the execute block
module file_space_model (
   input  wire logic       sys_clk, // Core clock
   input  wire logic [6:0] rdAddr,  // Address from instruction
   output logic      [7:0] rdData,  // Addressed register value
   input  wire logic       wrEn,    // Write pulse
   input  wire logic [6:0] wrAddr,  // Write address
   input  wire logic [7:0] wrData   // Write data
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] mem [128]; // Register contents

   // Distinct start contents
   initial
   begin
      for (int i = 0; i < 128; i++)
      begin
         mem[i] = 8'(i * 37 + 11);
      end
   end

   // Read follows the address at once
   assign rdData = mem[rdAddr];

   always @(posedge sys_clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
   end
endmodule

`default_nettype wire

// [dv/tb.sv]
`include "add_and_bit_defines.svh"
`default_nettype none

// Self-checking bench for the add, and and bit execute block
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic                sys_clk       = 1'b0;   // Core clock
   logic                rst_n         = 1'b0;   // Reset, active low
   logic [`INSTR_W-1:0] instrWord     = '0;     // Offered instruction
   logic                instrValid    = 1'b0;   // Offer strobe
   logic                operandIsPort = 1'b0;   // Operand is a port
   logic [7:0]          portPins      = 8'h00;  // Pin levels
   logic [7:0]          fileRdData;             // From register space
   logic                instrReady;             // Accept
   logic [7:0]          accum;                  // Accumulator
   logic                carryFlag;              // Carry flag
   logic                nibbleFlag;             // Nibble carry flag
   logic                zeroFlag;               // Zero flag
   logic                fileWrEn;               // Write pulse
   logic [6:0]          fileWrAddr;             // Write address
   logic [7:0]          fileWrData;             // Write data
   logic                discardPulse;           // Discard pulse
   logic [7:0]          expAcc        = 8'h00;  // Expected accumulator
   logic [2:0]          expFlags      = 3'h0;   // Expected carry, nibble, zero
   int                  fail_count    = 0;      // Mismatches
   int                  checks        = 0;      // Comparisons

   // Clock, 4 ns period
   always #2 sys_clk = ~sys_clk;

   add_and_bit_op_execute dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .instrWord(instrWord), .instrValid(instrValid),
      .fileRdData(fileRdData), .operandIsPort(operandIsPort), .portPins(portPins),
      .instrReady(instrReady), .accum(accum), .carryFlag(carryFlag),
      .nibbleFlag(nibbleFlag), .zeroFlag(zeroFlag), .fileWrEn(fileWrEn),
      .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .discardPulse(discardPulse)
   );

   file_space_model part (
      .sys_clk(sys_clk), .rdAddr(instrWord[6:0]), .rdData(fileRdData),
      .wrEn(fileWrEn), .wrAddr(fileWrAddr), .wrData(fileWrData)
   );

   // Verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // One comparison
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Accumulator and flags against the model
   task automatic chk_state();
      chk(accum, expAcc);
      chk({5'h00, carryFlag, nibbleFlag, zeroFlag}, {5'h00, expFlags});
   endtask

   // Write pulse, address and data
   task automatic chk_write(input logic [6:0] a, input logic [7:0] d);
      chk({7'h00, fileWrEn}, 8'h01);
      chk({1'b0, fileWrAddr}, {1'b0, a});
      chk(fileWrData, d);
   endtask

   // Offer one instruction, held until the taking edge
   task automatic put(input logic [`INSTR_W-1:0] w);
      @(negedge sys_clk);
      instrValid = 1'b1;
      instrWord  = w;
      @(posedge sys_clk);
   endtask

   // Offer one instruction, then withdraw with results settled
   task automatic go(input logic [`INSTR_W-1:0] w);
      put(w);
      @(negedge sys_clk);
      instrValid = 1'b0;
   endtask

   // Expected effect of an immediate add
   task automatic model_add(input logic [7:0] k);
      logic [8:0] s;
      logic [4:0] n;
      s        = {1'b0, expAcc} + {1'b0, k};
      n        = {1'b0, expAcc[3:0]} + {1'b0, k[3:0]};
      expAcc   = s[7:0];
      expFlags = {s[8], n[4], s[7:0] == 8'h00};
   endtask

   // Immediate add issued and modelled
   task automatic add_imm(input logic [7:0] k);
      model_add(k);
      go({6'b111110, k});
   endtask

   function automatic logic [13:0] reg_w(logic [3:0] s, logic d, logic [6:0] f);
      return {2'b00, s, d, f};
   endfunction

   function automatic logic [13:0] bit_w(logic [1:0] m, logic [2:0] b, logic [6:0] f);
      return {2'b01, m, b, f};
   endfunction

   // Immediate adds with carry out of both bit 7 and bit 3
   task automatic t_add_imm();
      add_imm(8'h8f);
      chk_state();
      add_imm(8'h71);
      chk_state();
   endtask

   // Register add to each target
   task automatic t_add_reg();
      add_imm(8'h05);
      part.mem[7'h20] = 8'h0c;
      go(reg_w(4'h7, 1'b1, 7'h20));
      chk_write(7'h20, 8'h11);
      expFlags = 3'b010;
      chk_state();
      part.mem[7'h7f] = 8'hfb;
      go(reg_w(4'h7, 1'b0, 7'h7f));
      chk({7'h00, fileWrEn}, 8'h00);
      expAcc   = 8'h00;
      expFlags = 3'b111;
      chk_state();
   endtask

   // Ands keep carry and nibble flags
   task automatic t_and();
      add_imm(8'hff);
      add_imm(8'h81);
      chk_state();
      part.mem[7'h21] = 8'h3c;
      go(reg_w(4'h5, 1'b1, 7'h21));
      chk_write(7'h21, 8'h00);
      expFlags = 3'b111;
      chk_state();
      go({6'b111001, 8'hc0});
      expFlags = 3'b110;
      chk_state();
      // Register and into the accumulator, result zero
      part.mem[7'h22] = 8'h7f;
      go(reg_w(4'h5, 1'b0, 7'h22));
      chk({7'h00, fileWrEn}, 8'h00);
      expAcc   = 8'h00;
      expFlags = 3'b111;
      chk_state();
      // Immediate add with the low sub bit set
      model_add(8'h2a);
      go({6'b111111, 8'h2a});
      chk_state();
      // Opcode outside the group changes nothing
      go({6'b111000, 8'hff});
      chk({7'h00, fileWrEn}, 8'h00);
      chk_state();
   endtask

   // Set and clear at every bit position
   task automatic t_bits();
      logic [7:0] m;
      for (int b = 0; b < 8; b++)
      begin
         for (int s = 0; s < 2; s++)
         begin
            m = 8'h01 << b;
            // Let the previous write-back land before presetting
            @(negedge sys_clk);
            part.mem[7'h30] = 8'h5a;
            go(bit_w(2'(s), 3'(b), 7'h30));
            chk_write(7'h30, (s == 1) ? (8'h5a | m) : (8'h5a & ~m));
            chk_state();
         end
      end
   endtask

   // Both skip tests on a low and a high bit, next instruction back to back
   task automatic t_skip();
      logic taken;
      part.mem[7'h31] = 8'h10;
      for (int m = 2; m < 4; m++)
      begin
         for (int b = 3; b < 5; b++)
         begin
            taken = (m == 2) ? (b == 3) : (b == 4);
            put(bit_w(2'(m), 3'(b), 7'h31));
            put({6'b111110, 8'h01});
            @(negedge sys_clk);
            instrValid = 1'b0;
            if (!taken)
               model_add(8'h01);
            chk({7'h00, discardPulse}, {7'h00, taken});
            chk_state();
         end
      end
   endtask

   // Bit set on a port uses pin levels
   task automatic t_port();
      operandIsPort = 1'b1;
      portPins = 8'ha5;
      part.mem[7'h05] = 8'h00;
      repeat (8) @(negedge sys_clk);
      go(bit_w(2'b01, 3'd1, 7'h05));
      chk_write(7'h05, 8'ha7);
      operandIsPort = 1'b0;
   endtask

   // Reset in mid-run clears outputs and a pending skip
   task automatic t_reset();
      go(bit_w(2'b10, 3'd3, 7'h31));
      rst_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      expAcc   = 8'h00;
      expFlags = 3'h0;
      chk_state();
      chk({7'h00, instrReady}, 8'h00);
      chk({7'h00, fileWrEn}, 8'h00);
      chk({7'h00, discardPulse}, 8'h00);
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk({7'h00, instrReady}, 8'h01);
      // Next instruction runs, the skip was forgotten
      add_imm(8'h01);
      chk({7'h00, discardPulse}, 8'h00);
      chk_state();
   endtask

   // Hang guard
   initial
   begin
      #20000;
      fail_count++;
      close_out();
   end

   // Main sequence
   initial
   begin
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk({7'h00, instrReady}, 8'h01);
      t_add_imm();
      t_add_reg();
      t_and();
      t_bits();
      t_skip();
      t_port();
      t_reset();
      close_out();
   end
endmodule

`default_nettype wire
